// File: core/lsi_regs.svh
// Register offsets, field positions and reset values of the lock status and interrupt logic.
// Assumes byte-wide registers on the serial configuration port, 8-bit addresses.
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH

`define LSI_ADDR_IRQ_ENABLE 8'h03
`define LSI_ADDR_IRQ_STATUS 8'h04
`define LSI_ADDR_RCV_STATUS 8'h21
`define LSI_ADDR_PH_CTRL 8'h26
`define LSI_ADDR_DELAY_LO 8'h27
`define LSI_ADDR_DELAY_HI 8'h28
`define LSI_ADDR_SEARCH_CFG 8'h29
`define LSI_ADDR_PH_STATUS 8'h2a

`define LSI_IRQ_RCV_LOCKED 0
`define LSI_IRQ_RCV_LOST 1
`define LSI_IRQ_PH_LOCKED 2
`define LSI_IRQ_PH_LOST 3

`define LSI_RCV_LOCKED_BIT 0
`define LSI_RCV_LOST_BIT 1
`define LSI_RCV_TRACK_BIT 3
`define LSI_PH_LOCKED_BIT 0
`define LSI_PH_LOST_BIT 1

`define LSI_CTRL_ENABLE_BIT 1
`define LSI_CTRL_READ_BIT 3
`define LSI_CFG_RESTART_BIT 5
`define LSI_CFG_RETRY_BIT 6

`define LSI_LOSE_STEPS 4
`define LSI_REGAIN_STEPS 3
`define LSI_TAP_MAX 432
`define LSI_TAP_INIT 9'h0d8

`define LSI_IRQ_ENABLE_RST 8'h00
`define LSI_CTRL_RST 8'h00
`define LSI_CFG_RST 8'h00

`endif

// File: core/lsi_pkg.sv
// Types shared by the lock status and interrupt logic.
// Assumes nothing of its surroundings.
package lsi_pkg;
	typedef enum logic [3:0] {
		LSI_IDLE = 4'b0001,
		LSI_SEARCH = 4'b0010,
		LSI_TRACK = 4'b0100,
		LSI_FAILED = 4'b1000
	} lsi_state_t;
endpackage

// File: core/lsi_edge_flag.sv
// One sticky interrupt flag set on a rising edge of its condition.
// Assumes the condition is synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module lsi_edge_flag (
	input wire logic clock, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic cond, // Live condition
	input wire logic enable, // Enable bit; low clears the flag
	output logic flag // Sticky flag
);
	logic cond_reg;
	wire rise = cond & ~cond_reg;
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cond_reg <= 1'b0;
			flag <= 1'b0;
		end else begin
			cond_reg <= cond;
			flag <= rise | (flag & enable);
		end
	end
endmodule
`default_nettype wire

// File: core/lsi_lock_irq.sv
// Phase delay controller lock tracking, status registers and interrupt request.
// Assumes a byte register port decoded from the serial configuration port, and
// phase measurements and receiver status supplied synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"

// Functional notes
// - Exact phase and slope match enters tracking
// - Deviation over four clears locked, sets lost
// - Within three steps: locked set, lost cleared
// - Phase status at 0x2A bits 0,1
// - Clock disruption or out-of-range tap loses lock
// - Restart bit chooses tracking or new search
// - Readback bit shows delay and phase used
// - Interrupt output reports lock and loss events
// - Interrupt output is active high
// - Enable register mirrors status register layout
// - Bits: phase lost, locked, receiver lost, locked
// - Status bits set on rising condition only
// - Writing enable low clears its status
// - Receiver status: tracking 3, lost 1, locked 0
// - Endpoint search failure retries or stops
module lsi_lock_irq #(
	parameter int TAP_MAX = `LSI_TAP_MAX
) (
	input wire logic clock, // System clock, 125 MHz
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	output logic [7:0] reg_rdata, // Register read data
	input wire logic [4:0] measured_phase, // Phase measured at current tap
	input wire logic phase_slope_ok, // Measured slope matches target
	input wire logic converter_clock_ok, // Converter clock present
	input wire logic receiver_locked_flag, // Receiver locked, live
	input wire logic receiver_lost_flag, // Receiver lost, live
	input wire logic receiver_tracking_active, // Receiver tracking, live
	output logic [8:0] delay_tap_setting, // Delay tap in use
	output logic irq // Interrupt request, active high
);
	// The tap and search arithmetic are nine and ten bits wide
	if (TAP_MAX < 1 || TAP_MAX > 511) begin : g_bad_tap
		$error("TAP_MAX out of range");
	end

	lsi_pkg::lsi_state_t state_reg, state_next;
	logic [7:0] irq_enable_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] cfg_reg;
	logic [8:0] init_tap_reg;
	logic [4:0] target_phase;
	logic [8:0] tap_reg, tap_next;
	logic phase_locked_flag, phase_lost_flag, held_lock_reg;
	logic [8:0] search_step_reg;
	logic search_dir_reg;
	logic [3:0] irq_flags;

	wire wr_en = reg_wr && reg_addr == `LSI_ADDR_IRQ_ENABLE;
	wire wr_ctrl = reg_wr && reg_addr == `LSI_ADDR_PH_CTRL;
	wire wr_lo = reg_wr && reg_addr == `LSI_ADDR_DELAY_LO;
	wire wr_hi = reg_wr && reg_addr == `LSI_ADDR_DELAY_HI;
	wire wr_cfg = reg_wr && reg_addr == `LSI_ADDR_SEARCH_CFG;
	wire ctl_enable = ctrl_reg[`LSI_CTRL_ENABLE_BIT];
	wire readback = ctrl_reg[`LSI_CTRL_READ_BIT];
	wire restart_on_loss = cfg_reg[`LSI_CFG_RESTART_BIT];
	wire retry_search = cfg_reg[`LSI_CFG_RETRY_BIT];

	// Absolute phase deviation, signed 5-bit difference
	wire [4:0] phase_diff = 5'(measured_phase - target_phase);
	wire [4:0] phase_dev = phase_diff[4] ? 5'(-phase_diff) : phase_diff;
	wire exact_match = phase_dev == 5'h0 && phase_slope_ok;
	wire tap_in_range = tap_reg <= 9'(TAP_MAX);
	wire lose_cond = phase_dev > 5'(`LSI_LOSE_STEPS) || !converter_clock_ok || !tap_in_range;
	wire regain_cond = phase_dev <= 5'(`LSI_REGAIN_STEPS) && converter_clock_ok && tap_in_range;
	wire in_track = state_reg == lsi_pkg::LSI_TRACK;

	// Alternating search offset around the start tap
	wire [9:0] probe_up = 10'(init_tap_reg) + 10'(search_step_reg);
	wire [9:0] probe_dn = 10'(init_tap_reg) - 10'(search_step_reg);
	wire hit_end = (search_dir_reg && probe_up > 10'(TAP_MAX)) || (!search_dir_reg && probe_dn[9]);
	wire track_up = phase_diff[4];
	wire track_dn = !phase_diff[4] && phase_diff != 5'h0;

	always_comb begin
		state_next = state_reg;
		tap_next = tap_reg;
		unique case (state_reg)
			lsi_pkg::LSI_IDLE: begin
				if (ctl_enable) begin
					state_next = lsi_pkg::LSI_SEARCH;
					tap_next = init_tap_reg;
				end
			end
			lsi_pkg::LSI_SEARCH: begin
				if (exact_match)
					state_next = lsi_pkg::LSI_TRACK;
				else if (hit_end) begin
					if (retry_search)
						tap_next = init_tap_reg;
					else
						state_next = lsi_pkg::LSI_FAILED;
				end else
					tap_next = search_dir_reg ? probe_up[8:0] : probe_dn[8:0];
			end
			lsi_pkg::LSI_TRACK: begin
				if (phase_locked_flag && lose_cond && restart_on_loss) begin
					state_next = lsi_pkg::LSI_SEARCH;
					tap_next = init_tap_reg;
				end else if (track_up && tap_reg < 9'(TAP_MAX))
					tap_next = 9'(tap_reg + 9'h001);
				else if (track_dn && tap_reg != 9'h000)
					tap_next = 9'(tap_reg - 9'h001);
			end
			lsi_pkg::LSI_FAILED: begin
				// A fresh control write with the enable set starts a new search
				if (wr_ctrl && reg_wdata[`LSI_CTRL_ENABLE_BIT]) begin
					state_next = lsi_pkg::LSI_SEARCH;
					tap_next = init_tap_reg;
				end
			end
		endcase
		if (!ctl_enable)
			state_next = lsi_pkg::LSI_IDLE;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= lsi_pkg::LSI_IDLE;
			tap_reg <= `LSI_TAP_INIT;
		end else begin
			state_reg <= state_next;
			tap_reg <= tap_next;
		end
	end

	// Search walk: step grows after each up/down pair
	always_ff @(posedge clock) begin
		if (!nrst || state_reg != lsi_pkg::LSI_SEARCH || hit_end) begin
			search_step_reg <= 9'h001;
			search_dir_reg <= 1'b1;
		end else begin
			search_dir_reg <= ~search_dir_reg;
			if (!search_dir_reg)
				search_step_reg <= 9'(search_step_reg + 9'h001);
		end
	end

	// Lock status hysteresis
	always_ff @(posedge clock) begin
		if (!nrst || !in_track) begin
			phase_locked_flag <= 1'b0;
			phase_lost_flag <= 1'b0;
			held_lock_reg <= 1'b0;
		end else if (!phase_locked_flag && !held_lock_reg) begin
			phase_locked_flag <= 1'b1;
			held_lock_reg <= 1'b1;
		end else if (phase_locked_flag && lose_cond) begin
			phase_locked_flag <= 1'b0;
			phase_lost_flag <= held_lock_reg;
		end else if (!phase_locked_flag && regain_cond) begin
			phase_locked_flag <= 1'b1;
			phase_lost_flag <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_enable_reg <= `LSI_IRQ_ENABLE_RST;
			ctrl_reg <= `LSI_CTRL_RST;
			cfg_reg <= `LSI_CFG_RST;
			init_tap_reg <= `LSI_TAP_INIT;
			target_phase <= 5'h00;
		end else begin
			if (wr_en)
				irq_enable_reg <= {4'h0, reg_wdata[3:0]};
			if (wr_ctrl)
				ctrl_reg <= reg_wdata;
			if (wr_cfg)
				cfg_reg <= reg_wdata;
			if (wr_lo) begin
				target_phase <= reg_wdata[7:3];
				init_tap_reg[8] <= reg_wdata[0];
			end
			if (wr_hi)
				init_tap_reg[7:0] <= reg_wdata;
		end
	end

	// Live conditions per interrupt source
	wire [3:0] irq_cond = {phase_lost_flag, phase_locked_flag, receiver_lost_flag, receiver_locked_flag};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			lsi_edge_flag u_flag (
				.clock(clock),
				.nrst(nrst),
				.cond(irq_cond[gi]),
				.enable(irq_enable_reg[gi]),
				.flag(irq_flags[gi])
			);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(irq_flags & irq_enable_reg[3:0]);
	end

	assign delay_tap_setting = tap_reg;

	// Readback shows values in use when the read bit is set
	wire [8:0] rb_tap = readback ? tap_reg : init_tap_reg;
	wire [7:0] rd_ph = {6'h00, phase_lost_flag, phase_locked_flag};
	wire [7:0] rd_rcv = {4'h0, receiver_tracking_active, 1'b0, receiver_lost_flag, receiver_locked_flag};
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			`LSI_ADDR_IRQ_ENABLE: rd_mux = irq_enable_reg;
			`LSI_ADDR_IRQ_STATUS: rd_mux = {4'h0, irq_flags};
			`LSI_ADDR_RCV_STATUS: rd_mux = rd_rcv;
			`LSI_ADDR_PH_CTRL: rd_mux = ctrl_reg;
			`LSI_ADDR_DELAY_LO: rd_mux = {target_phase, 2'b00, rb_tap[8]};
			`LSI_ADDR_DELAY_HI: rd_mux = rb_tap[7:0];
			`LSI_ADDR_SEARCH_CFG: rd_mux = cfg_reg;
			`LSI_ADDR_PH_STATUS: rd_mux = rd_ph;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rd_mux;
	end
endmodule
`default_nettype wire

// File: verification/lsi_phase_model.sv
// Phase detector stand-in: measured phase follows the tap in use.
// Assumes the tap comes from the design and the skew from the bench.
`timescale 1ns/1ps
`default_nettype none
module lsi_phase_model (
	input wire logic clock, // System clock
	input wire logic clk_ok, // Converter clock running
	input wire logic [8:0] skew, // Tap where phase reads zero
	input wire logic [8:0] tap, // Tap in use
	output logic [4:0] phase, // Measured phase
	output logic slope_ok // Slope matches
);
	logic [4:0] junk = 5'h10;
	// Without a clock the detector toggles between 0x10 and 0x0F, far from the bench target
	always_ff @(posedge clock) junk <= ~junk;
	assign phase = clk_ok ? 5'(tap - skew) : junk;
	assign slope_ok = clk_ok;
endmodule
`default_nettype wire

// File: verification/lsi_lock_irq_monitor.sv
// Checker on the lock status and interrupt ports.
// Assumes it is bound to lsi_lock_irq.
`timescale 1ns/1ps
`default_nettype none
module lsi_lock_irq_monitor #(
	parameter int TAP_MAX = 432
) (
	input wire logic clock, // Clock
	input wire logic nrst, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic receiver_locked_flag, // Rcv locked
	input wire logic receiver_lost_flag, // Rcv lost
	input wire logic receiver_tracking_active, // Rcv tracking
	input wire logic [8:0] delay_tap_setting, // Tap
	input wire logic irq // Interrupt
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !irq && reg_rdata == 8'h00)
		else $error("outputs not cleared");
	a_reset_tap: assert property (disable iff (1'b0) !nrst |=> delay_tap_setting == 9'h0d8)
		else $error("tap not reset");
	a_tap_range: assert property (delay_tap_setting <= 9'(TAP_MAX))
		else $error("tap out of range");
	a_unmapped_zero: assert property (
		!(reg_addr inside {8'h03, 8'h04, 8'h21, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rcv_status: assert property (reg_addr == 8'h21 |=> reg_rdata == {4'h0,
		$past(receiver_tracking_active), 1'b0, $past(receiver_lost_flag), $past(receiver_locked_flag)})
		else $error("receiver status wrong");
	a_enable_echo: assert property (reg_wr && reg_addr == 8'h03 ##1 !reg_wr && reg_addr == 8'h03
		|=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
		else $error("enable readback wrong");
	a_irq_clear: assert property (reg_wr && reg_addr == 8'h03 && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
		else $error("irq not cleared");
	a_status_nonzero: assert property (
		reg_addr == 8'h04 && irq && !reg_wr && !$past(reg_wr) |=> reg_rdata[3:0] != 4'h0)
		else $error("irq without status");
endmodule
bind lsi_lock_irq lsi_lock_irq_monitor #(.TAP_MAX(TAP_MAX)) mon (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .receiver_locked_flag(receiver_locked_flag),
	.receiver_lost_flag(receiver_lost_flag), .receiver_tracking_active(receiver_tracking_active),
	.delay_tap_setting(delay_tap_setting), .irq(irq));
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the lock status and interrupt logic.
// Assumes lsi_phase_model feeds the phase inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, nrst, reg_wr, rd, clk_ok, slope_ok, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, e;
	logic [2:0] rcv;
	logic [4:0] phase;
	logic [8:0] tap;
	logic [7:0] exp_q[$];
	int n_errors, cmp_count, cyc, i;
	lsi_lock_irq DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rdata(reg_rdata), .measured_phase(phase), .phase_slope_ok(slope_ok), .converter_clock_ok(clk_ok),
		.receiver_locked_flag(rcv[0]), .receiver_lost_flag(rcv[1]), .receiver_tracking_active(rcv[2]),
		.delay_tap_setting(tap), .irq(irq));
	lsi_phase_model pm (.clock(clock), .clk_ok(clk_ok), .skew(9'h0d6), .tap(tap), .phase(phase),
		.slope_ok(slope_ok));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test;
		end
	end
	always @(posedge clock) begin
		if (rd) begin
			#2;
			e = exp_q.pop_front();
			cmp_count++;
			if (reg_rdata !== e) begin
				n_errors++;
				$display("FAIL %0t read %h want %h", $time, reg_rdata, e);
			end
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1 reg_wr = 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] x);
		@(posedge clock);
		#1 reg_addr = a;
		exp_q.push_back(x);
		rd = 1'b1;
		@(posedge clock);
		#1 rd = 1'b0;
	endtask
	task automatic wait_irq;
		for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clock);
		cmp_count++;
		if (irq !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t no interrupt", $time);
		end
		#1;
	endtask
	initial begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		rd = 1'b0;
		rcv = 3'b000;
		clk_ok = 1'b1;
		v = 8'($urandom(63));
		repeat (12) @(posedge clock);
		#1 nrst = 1'b1;
		chk(8'h55, 8'h00);
		wr(8'h04, 8'hff);
		chk(8'h04, 8'h00);
		for (i = 0; i < 6; i++) begin
			v = 8'($urandom);
			rcv = 3'($urandom);
			wr(8'h03, v);
			chk(8'h03, {4'h0, v[3:0]});
			chk(8'h21, {4'h0, rcv[2], 1'b0, rcv[1:0]});
		end
		wr(8'h03, 8'h00);
		chk(8'h04, 8'h00);
		wr(8'h03, 8'h04);
		wr(8'h27, 8'h30);
		wr(8'h28, 8'hd8);
		wr(8'h29, 8'h00);
		wr(8'h26, 8'h0a);
		wait_irq;
		chk(8'h04, 8'h04);
		chk(8'h2a, 8'h01);
		chk(8'h27, 8'h30);
		chk(8'h28, 8'hdc);
		cmp_count++;
		if (tap !== 9'h0dc) begin
			n_errors++;
			$display("FAIL %0t tap %h want 0dc", $time, tap);
		end
		wr(8'h03, 8'h00);
		wr(8'h03, 8'h0c);
		chk(8'h04, 8'h00);
		clk_ok = 1'b0;
		wait_irq;
		chk(8'h2a, 8'h02);
		chk(8'h04, 8'h08);
		wr(8'h03, 8'h00);
		wr(8'h03, 8'h04);
		clk_ok = 1'b1;
		wait_irq;
		chk(8'h2a, 8'h01);
		wr(8'h03, 8'h00);
		wr(8'h03, 8'h08);
		wr(8'h29, 8'h20);
		clk_ok = 1'b0;
		wait_irq;
		chk(8'h2a, 8'h00);
		chk(8'h04, 8'h08);
		wr(8'h03, 8'h00);
		wr(8'h03, 8'h04);
		repeat (600) @(posedge clock);
		#1 clk_ok = 1'b1;
		repeat (20) @(posedge clock);
		chk(8'h2a, 8'h00);
		chk(8'h04, 8'h00);
		wr(8'h26, 8'h03);
		wait_irq;
		chk(8'h04, 8'h04);
		chk(8'h2a, 8'h01);
		chk(8'h28, 8'hd8);
		repeat (2) @(posedge clock);
		finish_test;
	end
endmodule
`default_nettype wire
